// [core/crs_defines.svh]
/*
  constants for the cpu reset / interrupt sequencer: vectors, stack reset,
  ccr bit positions, sequence lengths.
  assumes inclusion by bare name from core files.
*/
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
`define CRS_VEC_RESET_HI 16'hFFFE
`define CRS_VEC_RESET_LO 16'hFFFF
`define CRS_SP_RESET     16'h00FF
`define CRS_CCR_RESET    8'h68
`define CRS_CCR_I_BIT    3
`define CRS_STACK_BYTES  3'h4
`define CRS_QUEUE_FILL   2'h3
`endif

// [core/crs_pkg.sv]
/*
  types for the cpu reset / interrupt sequencer.
  assumes crs_defines.svh is available.
*/
package crs_pkg;
  typedef enum logic [10:0] {
    ST_RESET  = 11'h001,
    ST_VHI    = 11'h002,
    ST_VLO    = 11'h004,
    ST_FREE   = 11'h008,
    ST_FETCH  = 11'h010,
    ST_RUN    = 11'h020,
    ST_STACK  = 11'h040,
    ST_IVHI   = 11'h080,
    ST_IVLO   = 11'h100,
    ST_LOWPWR = 11'h200,
    ST_BGND   = 11'h400
  } crs_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } crs_bus_t;

  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  idx_lo;
    logic [7:0]  condition_code_register;
    logic [15:0] pc;
  } crs_regs_t;

  typedef struct packed {
    crs_state_t  state;
    crs_bus_t    bus;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0]  condition_code_register;
    logic [2:0]  cnt;
    logic        rd_pend;
    logic [1:0]  rd_kind;
    logic [1:0]  q_cnt;
    logic        q_fill;
    logic [15:0] ivec;
    logic [15:0] opaddr;
    logic        clk_run;
    logic        osc_off;
    logic        in_bgnd;
    logic        seq_done;
  } crs_st_t;
endpackage

// [core/crs_sequencer.sv]
/*
  reset exit, interrupt entry, wait/stop and stack-pointer operand address
  sequencing for an 8-bit cpu core.
  assumes decode supplies instruction-boundary and control strobes, memory
  returns read data in the read's own bus cycle, reset is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.svh"

module crs_sequencer (
  // clock, reset, enable
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_ce,
  // memory read return
  input  wire logic [7:0]        i_rdata,
  // cpu registers to stack
  input  wire crs_pkg::crs_regs_t i_regs,
  // decode strobes
  input  wire logic              i_instr_end,
  input  wire logic              i_swi,
  input  wire logic              i_wait,
  input  wire logic              i_stop,
  input  wire logic              i_stop_osc,
  input  wire logic              i_tfr_hx,
  input  wire logic [15:0]       i_hx,
  input  wire logic              i_sp2_req,
  input  wire logic [15:0]       i_offset16,
  input  wire logic              i_clr_i,
  input  wire logic              i_set_i,
  // interrupt request, vector of highest pending
  input  wire logic              i_irq,
  input  wire logic [15:0]       i_irq_vec,
  // debug halt and resume
  input  wire logic              i_dbg_halt,
  input  wire logic              i_dbg_go,
  // bus
  output crs_pkg::crs_bus_t      o_bus,
  // state
  output logic [15:0]            o_pc,
  output logic [15:0]            o_sp,
  output logic [7:0]             o_ccr,
  output logic [15:0]            o_opaddr,
  output logic [1:0]             o_q_cnt,
  output logic                   o_q_fill,
  output logic                   o_clk_run,
  output logic                   o_osc_off,
  output logic                   o_bgnd,
  output logic                   o_seq_done
);

  crs_pkg::crs_st_t s_q;
  crs_pkg::crs_st_t s_d;

  //--------------------------------------------------------------
  // next state
  //--------------------------------------------------------------
  always_comb begin
    logic irq_ok;
    irq_ok = 1'b0;
    s_d = s_q;
    s_d.bus.rd = 1'b0;
    s_d.bus.wr = 1'b0;
    s_d.seq_done = 1'b0;
    // read data lands in the read cycle itself, taken at its closing edge
    s_d.rd_pend = 1'b0;
    if (s_q.rd_pend) begin
      case (s_q.rd_kind)
        2'd0: s_d.pc[15:8] = i_rdata;
        2'd1: s_d.pc[7:0]  = i_rdata;
        default: s_d.q_cnt = (s_q.q_cnt == 2'd3) ? 2'd3 : s_q.q_cnt + 2'd1;
      endcase
    end
    // long offset from stack pointer, sp untouched
    if (i_sp2_req) begin
      s_d.opaddr = s_q.sp + i_offset16;
    end
    irq_ok = i_irq && !s_q.condition_code_register[`CRS_CCR_I_BIT];
    case (s_q.state)
      crs_pkg::ST_RESET: begin
        // first edge after release, aligned to bus clock
        s_d.clk_run = 1'b1;
        s_d.bus.addr = `CRS_VEC_RESET_HI;
        s_d.bus.rd = 1'b1;
        s_d.rd_pend = 1'b1;
        s_d.rd_kind = 2'd0;
        s_d.q_cnt = 2'd0;
        s_d.state = crs_pkg::ST_VHI;
      end
      crs_pkg::ST_VHI, crs_pkg::ST_IVHI: begin
        s_d.bus.addr = (s_q.state == crs_pkg::ST_VHI) ? `CRS_VEC_RESET_LO
                                                      : s_q.ivec + 16'h0001;
        s_d.bus.rd = 1'b1;
        s_d.rd_pend = 1'b1;
        s_d.rd_kind = 2'd1;
        s_d.state = (s_q.state == crs_pkg::ST_VHI) ? crs_pkg::ST_VLO
                                                   : crs_pkg::ST_IVLO;
      end
      crs_pkg::ST_VLO, crs_pkg::ST_IVLO: begin
        // free cycle: vector low byte not yet usable
        s_d.state = crs_pkg::ST_FREE;
      end
      crs_pkg::ST_FREE, crs_pkg::ST_FETCH: begin
        s_d.bus.addr = s_q.pc;
        s_d.bus.rd = 1'b1;
        s_d.rd_pend = 1'b1;
        s_d.rd_kind = 2'd2;
        s_d.pc = s_q.pc + 16'h0001;
        s_d.cnt = (s_q.state == crs_pkg::ST_FREE) ? 3'd1 : s_q.cnt + 3'd1;
        s_d.q_fill = 1'b1;
        if (s_q.state == crs_pkg::ST_FETCH
            && s_q.cnt + 3'd1 == {1'b0, `CRS_QUEUE_FILL}) begin
          s_d.state = crs_pkg::ST_RUN;
          s_d.seq_done = 1'b1;
          s_d.q_fill = 1'b0;
        end else begin
          s_d.state = crs_pkg::ST_FETCH;
        end
      end
      crs_pkg::ST_RUN: begin
        if (i_clr_i) begin
          s_d.condition_code_register[`CRS_CCR_I_BIT] = 1'b0;
        end
        if (i_set_i) begin
          s_d.condition_code_register[`CRS_CCR_I_BIT] = 1'b1;
        end
        if (i_tfr_hx) begin
          s_d.sp = i_hx - 16'h0001;
        end
        if (i_instr_end) begin
          if (i_dbg_halt) begin
            s_d.state = crs_pkg::ST_BGND;
            s_d.in_bgnd = 1'b1;
          end else if (i_swi || irq_ok) begin
            s_d.ivec = i_irq_vec;
            s_d.cnt = 3'd0;
            s_d.state = crs_pkg::ST_STACK;
          end else if (i_wait || i_stop) begin
            s_d.condition_code_register[`CRS_CCR_I_BIT] = 1'b0;
            s_d.clk_run = 1'b0;
            s_d.osc_off = i_stop && i_stop_osc;
            s_d.state = crs_pkg::ST_LOWPWR;
          end
        end
      end
      crs_pkg::ST_STACK: begin
        // pc lo, pc hi, index low, acc, ccr; index high is skipped
        s_d.bus.wr = 1'b1;
        s_d.bus.addr = s_q.sp;
        case (s_q.cnt)
          3'd0: s_d.bus.wdata = s_q.pc[7:0];
          3'd1: s_d.bus.wdata = s_q.pc[15:8];
          3'd2: s_d.bus.wdata = i_regs.idx_lo;
          3'd3: s_d.bus.wdata = i_regs.acc;
          default: s_d.bus.wdata = s_q.condition_code_register;
        endcase
        s_d.sp = s_q.sp - 16'h0001;
        s_d.cnt = s_q.cnt + 3'd1;
        // five pushes done: ccr went out last, now fetch the vector
        if (s_q.cnt == `CRS_STACK_BYTES + 3'd1) begin
          s_d.condition_code_register[`CRS_CCR_I_BIT] = 1'b1;
          s_d.bus.addr = s_q.ivec;
          s_d.bus.wr = 1'b0;
          s_d.bus.rd = 1'b1;
          s_d.rd_pend = 1'b1;
          s_d.rd_kind = 2'd0;
          s_d.sp = s_q.sp;
          s_d.q_cnt = 2'd0;
          s_d.state = crs_pkg::ST_IVHI;
        end
      end
      crs_pkg::ST_LOWPWR: begin
        if (i_irq) begin
          s_d.clk_run = 1'b1;
          s_d.osc_off = 1'b0;
          s_d.ivec = i_irq_vec;
          s_d.cnt = 3'd0;
          s_d.state = crs_pkg::ST_STACK;
        end
      end
      crs_pkg::ST_BGND: begin
        if (i_dbg_go) begin
          s_d.in_bgnd = 1'b0;
          s_d.cnt = 3'd0;
          s_d.q_cnt = 2'd0;
          s_d.state = crs_pkg::ST_FETCH;
        end
      end
      default: s_d.state = crs_pkg::ST_RESET;
    endcase
  end

  //--------------------------------------------------------------
  // state register
  //--------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      // abort whatever runs, clocks held stopped during reset
      s_q.state    <= crs_pkg::ST_RESET;
      s_q.bus      <= '0;
      s_q.pc       <= 16'h0000;
      s_q.sp       <= `CRS_SP_RESET;
      s_q.condition_code_register      <= `CRS_CCR_RESET;
      s_q.cnt      <= 3'd0;
      s_q.rd_pend  <= 1'b0;
      s_q.rd_kind  <= 2'd0;
      s_q.q_cnt    <= 2'd0;
      s_q.q_fill   <= 1'b0;
      s_q.ivec     <= 16'h0000;
      s_q.opaddr   <= 16'h0000;
      s_q.clk_run  <= 1'b0;
      s_q.osc_off  <= 1'b0;
      s_q.in_bgnd  <= 1'b0;
      s_q.seq_done <= 1'b0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_bus      = s_q.bus;
  assign o_pc       = s_q.pc;
  assign o_sp       = s_q.sp;
  assign o_ccr      = s_q.condition_code_register;
  assign o_opaddr   = s_q.opaddr;
  assign o_q_cnt    = s_q.q_cnt;
  assign o_q_fill   = s_q.q_fill;
  assign o_clk_run  = s_q.clk_run;
  assign o_osc_off  = s_q.osc_off;
  assign o_bgnd     = s_q.in_bgnd;
  assign o_seq_done = s_q.seq_done;

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  AST_VEC_HI_FIRST: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_RESET) |=> (o_bus.rd && o_bus.addr == 16'hFFFE))
    else $error("first exit cycle did not read vector high");
  AST_VEC_LO_NEXT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_VHI) |=> (o_bus.rd && o_bus.addr == 16'hFFFF))
    else $error("second exit cycle did not read vector low");
  AST_FREE_CYCLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_VLO) |=> (!o_bus.rd && !o_bus.wr))
    else $error("third exit cycle touched memory");
  AST_SIX_CYCLES: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_q.state == crs_pkg::ST_RESET && i_ce)[*1] ##1 i_ce[*5] |=> o_seq_done)
    else $error("reset exit not six cycles");
  AST_SP_RESET: assert property (@(posedge i_clk)
    $rose(i_rstn) |-> (o_sp == 16'h00FF && o_ccr[3]))
    else $error("stack pointer or mask wrong after reset");
  AST_MASK_BLOCKS: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_RUN && o_ccr[3] && i_instr_end && !i_swi
     && !i_dbg_halt) |=> (s_q.state != crs_pkg::ST_STACK))
    else $error("masked request entered interrupt");
  AST_SP2_ADDR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && i_sp2_req) |=> (o_opaddr == $past(o_sp) + $past(i_offset16)))
    else $error("long stack offset address wrong");
  AST_TFR_MINUS1: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_RUN && i_tfr_hx) |=> (o_sp == $past(i_hx) - 16'h0001))
    else $error("index copy not minus one");
  AST_WAIT_CLR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_RUN && i_instr_end && i_wait && !i_dbg_halt
     && !i_swi && !(i_irq && !o_ccr[3])) |=> (!o_ccr[3] && !o_clk_run))
    else $error("wait did not clear mask and stop clocks");

  //--------------------------------------------------------------
  // checks: entry, modes, reset and enable
  //--------------------------------------------------------------
  // ccr is the fifth and last byte stacked
  AST_PUSH_CCR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_STACK && s_q.cnt == 3'd4)
    |=> (o_bus.wr && o_bus.wdata == $past(o_ccr)))
    else $error("ccr not stacked as fifth byte");
  AST_ENTRY_MASK: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_STACK && s_q.cnt == 3'd5)
    |=> (o_ccr[3] && o_bus.rd && !o_bus.wr))
    else $error("entry did not mask and read vector");
  AST_SWI_UNMASKED: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_RUN && i_instr_end && i_swi && !i_dbg_halt)
    |=> (s_q.state == crs_pkg::ST_STACK))
    else $error("software trap did not enter stacking");
  AST_HALT_BGND: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_RUN && i_instr_end && i_dbg_halt) |=> o_bgnd)
    else $error("debug halt did not enter background");
  AST_WAKE_STACK: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_LOWPWR && i_irq)
    |=> (o_clk_run && s_q.state == crs_pkg::ST_STACK))
    else $error("wake did not restart clocks into entry");
  AST_FETCH_PC: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_FREE) |=> (o_bus.rd && o_bus.addr == $past(o_pc)))
    else $error("first fetch not at program counter");
  // while running, a long stack offset without an index copy leaves sp unmoved
  AST_SP_UNTOUCHED: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && s_q.state == crs_pkg::ST_RUN && i_sp2_req && !i_tfr_hx)
    |=> (o_sp == $past(o_sp)))
    else $error("long stack offset moved the stack pointer");
  AST_RESET_ABORT: assert property (@(posedge i_clk)
    (!i_rstn) |=> (s_q.state == crs_pkg::ST_RESET && !o_bus.wr && !o_clk_run))
    else $error("reset did not abort the sequence");
  AST_CE_FREEZE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!i_ce) |=> $stable(s_q))
    else $error("state moved while clock enable low");

endmodule
`default_nettype wire

// [verification/crs_mem_model.sv]
/*
  memory model on the far side of crs_sequencer: answers the read in its
  own bus cycle; the sequencer takes the byte at the cycle's closing edge.
  assumes a registered bus struct from the sequencer; writes are discarded.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_mem_model (
  // clock
  input  wire logic              i_clk,
  // bus from sequencer
  input  wire crs_pkg::crs_bus_t i_bus,
  // read data
  output logic [7:0]             o_rdata
);
  always_comb begin
    if (!i_bus.rd) begin
      o_rdata = ~i_bus.addr[7:0]; // no stale value outside reads
    end else if (i_bus.addr == 16'hfffe) begin
      o_rdata = 8'h12;
    end else if (i_bus.addr == 16'hffff) begin
      o_rdata = 8'h34;
    end else begin
      o_rdata = i_bus.addr[7:0] ^ 8'h5a;
    end
  end
endmodule
`default_nettype wire

// [verification/crs_sequencer_bench.sv]
/*
  bench for crs_sequencer: reset exit, stack addressing, interrupt entry,
  wait/stop, debug halt and reset abort.
  assumes crs_mem_model returns read data in the same cycle as the read.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_bench;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              ie = 1'b0, software_trap_instruction = 1'b0, wt = 1'b0, stp = 1'b0, osc = 1'b0;
  logic              tfr = 1'b0, sp2 = 1'b0, clr = 1'b0, set = 1'b0;
  logic              irq = 1'b0, halt = 1'b0, go = 1'b0, ce = 1'b1;
  logic [15:0]       hx = 16'h0000, off16 = 16'h0000, sp_m = 16'h00ff;
  logic [7:0]        rdata;
  crs_pkg::crs_regs_t regs = '{acc: 8'ha5, idx_lo: 8'h3c, condition_code_register: 8'h00, pc: 16'h0000};
  crs_pkg::crs_bus_t bus;
  logic [15:0]       pc, sp, opaddr;
  logic [7:0]        condition_code_register;
  logic [1:0]        qcnt;
  logic              qfill, clkrun, oscoff, bgnd, done;
  int                num_errors = 0, checked = 0, cycles = 0;
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  always #12.5 clk = ~clk;
  crs_sequencer uut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_rdata(rdata),
    .i_regs(regs), .i_instr_end(ie), .i_swi(software_trap_instruction), .i_wait(wt), .i_stop(stp),
    .i_stop_osc(osc), .i_tfr_hx(tfr), .i_hx(hx), .i_sp2_req(sp2), .i_offset16(off16),
    .i_clr_i(clr), .i_set_i(set), .i_irq(irq), .i_irq_vec(16'hfff0),
    .i_dbg_halt(halt), .i_dbg_go(go), .o_bus(bus), .o_pc(pc), .o_sp(sp), .o_ccr(condition_code_register),
    .o_opaddr(opaddr), .o_q_cnt(qcnt), .o_q_fill(qfill), .o_clk_run(clkrun),
    .o_osc_off(oscoff), .o_bgnd(bgnd), .o_seq_done(done));
  crs_mem_model mem (.i_clk(clk), .i_bus(bus), .o_rdata(rdata));
  task test_done;
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done;
    end
  end
  task step;
    @(posedge clk);
    #2;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask
  task end_instr;
    ie = 1'b1;
    step;
    ie = 1'b0;
  endtask
  task wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      step;
      n++;
    end
    check("seq_done", done, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task reset_hold;
    rstn = 1'b0;
    step;
    check("wr", bus.wr, 1'b0);
    check("sp", sp, 16'h00ff);
    check("mask", condition_code_register[3], 1'b1);
    check("clk_run", clkrun, 1'b0);
    step;
  endtask
  task reset_exit;
    logic [15:0] adr [6];
    adr = '{16'hfffe, 16'hffff, 16'h0000, 16'h1234, 16'h1235, 16'h1236};
    rstn = 1'b1;
    for (int i = 0; i < 6; i++) begin
      step;
      check("clk_run", clkrun, 1'b1);
      check("rd", bus.rd, i != 2);
      if (i != 2) check("addr", bus.addr, adr[i]);
    end
    check("seq_done", done, 1'b1);
    check("q_cnt", qcnt, 2'h2);
    sp_m = 16'h00ff;
  endtask
  task sp_ops;
    hx = 16'h0200;
    tfr = 1'b1;
    step;
    tfr = 1'b0;
    step;
    check("sp", sp, 16'h01ff);
    off16 = 16'h0105;
    sp2 = 1'b1;
    step;
    sp2 = 1'b0;
    step;
    check("opaddr", opaddr, 16'h0304);
    check("sp", sp, 16'h01ff);
    sp_m = 16'h01ff;
  endtask
  task freeze;
    ce = 1'b0;
    hx = 16'h0800;
    tfr = 1'b1;
    step;
    step;
    tfr = 1'b0;
    ce = 1'b1;
    step;
    check("sp_frozen", sp, 16'h01ff);
  endtask
  task entry(input logic [15:0] vec, input logic vchk);
    int n;
    n = 0;
    while (bus.wr !== 1'b1 && n < 8) begin
      step;
      n++;
    end
    for (int i = 0; i < 5; i++) begin
      check("push_addr", {bus.wr, bus.addr}, {1'b1, sp_m - 16'(i)});
      if (i == 2) check("push_x", bus.wdata, 8'h3c);
      if (i == 3) check("push_a", bus.wdata, 8'ha5);
      step;
    end
    check("vec_rd", {bus.rd, bus.wr}, 2'b10);
    if (vchk) check("vec_hi", bus.addr, vec);
    step;
    if (vchk) check("vec_lo", bus.addr, vec + 16'h0001);
    sp_m = sp_m - 16'h0005;
    irq = 1'b0;
    wait_done;
    check("sp", sp, sp_m);
    check("mask", condition_code_register[3], 1'b1);
  endtask
  task irq_cases;
    int w;
    irq = 1'b1;
    end_instr;
    w = 0;
    repeat (8) begin
      step;
      w += bus.wr;
    end
    check("masked_writes", w, 32'h0000_0000);
    clr = 1'b1;
    step;
    clr = 1'b0;
    repeat (4) begin
      step;
      w += bus.wr;
    end
    check("early_writes", w, 32'h0000_0000);
    end_instr;
    entry(16'hfff0, 1'b1);
  endtask
  task swi_masked;
    clr = 1'b1;
    set = 1'b1;
    step;
    clr = 1'b0;
    set = 1'b0;
    step;
    check("mask", condition_code_register[3], 1'b1);
    software_trap_instruction = 1'b1;
    end_instr;
    software_trap_instruction = 1'b0;
    entry(16'h0000, 1'b0);
  endtask
  task low_power;
    for (int k = 0; k < 2; k++) begin
      wt = (k == 0);
      stp = (k == 1);
      osc = (k == 1);
      end_instr;
      wt = 1'b0;
      stp = 1'b0;
      step;
      step;
      check("mask", condition_code_register[3], 1'b0);
      check("clk_run", clkrun, 1'b0);
      check("osc_off", oscoff, k == 1);
      irq = 1'b1;
      entry(16'hfff0, 1'b1);
      check("clk_run", clkrun, 1'b1);
    end
    osc = 1'b0;
  endtask
  task debug_halt;
    int n;
    halt = 1'b1;
    end_instr;
    step;
    check("bgnd", {bgnd, bus.wr}, 2'b10);
    halt = 1'b0;
    go = 1'b1;
    step;
    go = 1'b0;
    n = 0;
    while (bus.rd !== 1'b1 && n < 4) begin
      step;
      n++;
    end
    repeat (3) begin
      check("refill", bus.rd, 1'b1);
      step;
    end
    check("bgnd", bgnd, 1'b0);
  endtask
  task abort;
    int n;
    clr = 1'b1;
    step;
    clr = 1'b0;
    irq = 1'b1;
    end_instr;
    n = 0;
    while (bus.wr !== 1'b1 && n < 8) begin
      step;
      n++;
    end
    irq = 1'b0;
    reset_hold;
    reset_exit;
  endtask
  initial begin
    repeat (6) step;
    reset_hold;
    reset_exit;
    sp_ops;
    freeze;
    irq_cases;
    swi_masked;
    low_power;
    debug_halt;
    abort;
    test_done;
  end
endmodule
`default_nettype wire
